// [hdl/pdx_pkg.sv]
// Purpose: Constants for the port-write, OR and power-down executor
// Assumes: 10-bit instruction words, 4-bit data path
// Notes: Opcodes of the four handled instructions and the arming one
package pdx_pkg;
  localparam logic [9:0] OP_PORT1 = 10'h221;
  localparam logic [9:0] OP_PORT2 = 10'h222;
  localparam logic [9:0] OP_OR = 10'h019;
  localparam logic [9:0] OP_PDOWN = 10'h002;
  // Arming opcode is outside this block's set; arbitrary neutral default
  localparam logic [9:0] OP_ARM_DEF = 10'h2a3;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [1:0] P2_RST = 2'h0;
endpackage : pdx_pkg

// [hdl/pdx_exec.sv]
// Purpose: Executes port writes, accumulator OR and power-down entry
// Assumes: One instruction presented per cycle, strobed by INSTR_VALID
// Notes: Accumulator and carry live outside; this block gives their next values
// Notes: Port latches and back-up flag are the only state besides the arming mark and the residency counter
// Notes: Back-up is left only through NRST; no wake-up source is modelled here
// Notes: Arming opcode is a parameter so the core can place it in its own map
// Notes: Checks sit beside the logic; the bench only drives and compares
// Notes: One instruction per cycle; port and back-up results show one edge later, OR results in the same cycle
`timescale 1ns/10ps
module pdx_exec #(
  parameter logic [9:0] ARM_OPCODE = pdx_pkg::OP_ARM_DEF
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic INSTR_VALID,
  input wire logic [9:0] INSTR,
  input wire logic [3:0] ACC,
  input wire logic CARRY_IN,
  input wire logic [3:0] RAM_NIBBLE,
  output logic [3:0] ACC_NXT,
  output logic ACC_WE,
  output logic CARRY_OUT,
  output logic SKIP,
  output logic PC_INC,
  output logic [3:0] PORT_ONE,
  output logic [1:0] PORT_TWO,
  output logic BACKUP
);
  logic armed_r;
  logic [3:0] port_one_r;
  logic [1:0] port_two_r;
  logic backup_r;
  logic run;
  logic is_or;
  // Per-instruction decode used by the checks below
  logic is_port1;
  logic is_port2;
  logic is_pdown;
  logic is_arm;
  // Cycles spent in back-up, saturating, for long-residency checks
  logic [7:0] backup_cyc_r;
  localparam logic [7:0] CYC_SAT = 8'hff;
  localparam logic [7:0] CYC_ONE = 8'h01;
  localparam logic [7:0] CYC_ZERO = 8'h00;

  // Decode only counts while the core is running
  assign is_port1 = run && (INSTR == pdx_pkg::OP_PORT1);
  assign is_port2 = run && (INSTR == pdx_pkg::OP_PORT2);
  assign is_pdown = run && (INSTR == pdx_pkg::OP_PDOWN);
  assign is_arm = run && (INSTR == ARM_OPCODE);

  // Core stops fetching once in back-up; only reset wakes it here
  assign run = INSTR_VALID && !backup_r;
  assign is_or = run && (INSTR == pdx_pkg::OP_OR);

  // Accumulator result; carry passes untouched, no skip ever
  assign ACC_NXT = ACC | RAM_NIBBLE;
  assign ACC_WE = is_or;
  assign CARRY_OUT = CARRY_IN;
  assign SKIP = 1'b0;
  assign PC_INC = run;
  assign PORT_ONE = port_one_r;
  assign PORT_TWO = port_two_r;
  assign BACKUP = backup_r;

  // Port-one latch, full nibble
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port_one_r <= pdx_pkg::NIB_RST;
    end else if (run && INSTR == pdx_pkg::OP_PORT1) begin
      port_one_r <= ACC;
    end
  end

  // Port-two latch, low two bits only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port_two_r <= pdx_pkg::P2_RST;
    end else if (run && INSTR == pdx_pkg::OP_PORT2) begin
      port_two_r <= ACC[1:0];
    end
  end

  // Arming lasts exactly one executed instruction
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      armed_r <= 1'b0;
    end else if (run) begin
      armed_r <= (INSTR == ARM_OPCODE);
    end
  end

  // Back-up entry; a stray power-down is ignored
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      backup_r <= 1'b0;
    end else if (run && INSTR == pdx_pkg::OP_PDOWN && armed_r) begin
      backup_r <= 1'b1;
    end
  end

  port_one_a: assert property (@(posedge CLK) disable iff (!NRST)
    run && INSTR == pdx_pkg::OP_PORT1 |=> PORT_ONE == $past(ACC))
    else $error("port one not loaded");
  port_two_a: assert property (@(posedge CLK) disable iff (!NRST)
    run && INSTR == pdx_pkg::OP_PORT2 |=> PORT_TWO == $past(ACC[1:0]))
    else $error("port two not loaded");
  port_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    !(run && INSTR == pdx_pkg::OP_PORT1) |=> $stable(PORT_ONE))
    else $error("port one changed");
  or_result_a: assert property (@(posedge CLK) disable iff (!NRST)
    is_or |-> ACC_WE && ACC_NXT == (ACC | RAM_NIBBLE))
    else $error("or result wrong");
  backup_entry_a: assert property (@(posedge CLK) disable iff (!NRST)
    run && INSTR == ARM_OPCODE ##1 run && INSTR == pdx_pkg::OP_PDOWN |=> BACKUP)
    else $error("back-up not entered");
  stray_pdown_a: assert property (@(posedge CLK) disable iff (!NRST)
    run && INSTR != ARM_OPCODE ##1 run && INSTR == pdx_pkg::OP_PDOWN |=> !BACKUP)
    else $error("stray power-down acted");
  carry_kept_a: assert property (@(posedge CLK) disable iff (!NRST)
    CARRY_OUT == CARRY_IN && !SKIP)
    else $error("carry or skip disturbed");
  backup_stays_a: assert property (@(posedge CLK) disable iff (!NRST)
    BACKUP |=> BACKUP && !PC_INC)
    else $error("back-up left");

  // Residency counter; saturates so a long back-up never wraps to zero
  // Only read by the checks, so it costs nothing in the core itself
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      backup_cyc_r <= CYC_ZERO;
    end else if (backup_r && backup_cyc_r != CYC_SAT) begin
      backup_cyc_r <= backup_cyc_r + CYC_ONE;
    end
  end

  // Further checks: latches move only on their own instruction,
  // arming lasts one executed instruction, and back-up freezes ports, program counter and accumulator write

  // Port-two latch holds unless its own write executes
  // Guards against a decode that also catches the port-one code
  port_two_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    !is_port2 |=> $stable(PORT_TWO))
    else $error("port two changed");

  // Any change on port one must come from a port-one write
  // Catches a latch enable that leaks while refused
  port_one_cause_a: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(PORT_ONE) |-> $past(is_port1))
    else $error("port one changed without write");

  // Any change on port two must come from a port-two write
  // Upper accumulator bits can never reach it
  port_two_cause_a: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(PORT_TWO) |-> $past(is_port2))
    else $error("port two changed without write");

  // Accumulator loads on the OR instruction only
  // A stray write here would corrupt the core's working value
  acc_idle_a: assert property (@(posedge CLK) disable iff (!NRST)
    !is_or |-> !ACC_WE)
    else $error("accumulator written outside or");

  // OR leaves carry alone
  // Carry is shared with arithmetic outside this block
  or_carry_a: assert property (@(posedge CLK) disable iff (!NRST)
    is_or |-> CARRY_OUT == CARRY_IN && !SKIP)
    else $error("or disturbed carry");

  // Power-down never writes the accumulator, armed or not
  // Keeps the no-operation case truly inert
  pdown_no_acc_a: assert property (@(posedge CLK) disable iff (!NRST)
    is_pdown |-> !ACC_WE)
    else $error("power-down wrote accumulator");

  // Unarmed power-down leaves ports and back-up flag as they were
  // Only the program counter moves
  stray_quiet_a: assert property (@(posedge CLK) disable iff (!NRST)
    is_pdown && !armed_r |=> !BACKUP && $stable(PORT_ONE) && $stable(PORT_TWO))
    else $error("stray power-down had effect");

  // Any other executed instruction clears the arming mark
  // So arming never reaches past the next instruction
  arm_single_a: assert property (@(posedge CLK) disable iff (!NRST)
    run && !is_arm |=> !armed_r)
    else $error("arming outlived one instruction");

  // Idle cycles keep the arming mark
  // Invalid slots between arm and power-down do not break the pair
  arm_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    !run |=> $stable(armed_r))
    else $error("arming lost on idle cycle");

  // Back-up is entered only by an armed power-down
  // No other code path may set the sticky flag
  backup_cause_a: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(BACKUP) |-> $past(is_pdown) && $past(armed_r))
    else $error("back-up entered without armed power-down");

  // Ports freeze while in back-up
  // Instructions presented then are refused entirely
  refused_ports_a: assert property (@(posedge CLK) disable iff (!NRST)
    BACKUP |=> $stable(PORT_ONE) && $stable(PORT_TWO))
    else $error("port moved in back-up");

  // Program counter steps once per executed instruction
  // One word, one cycle for every instruction handled here
  pc_step_a: assert property (@(posedge CLK) disable iff (!NRST)
    PC_INC == (INSTR_VALID && !BACKUP))
    else $error("program counter step wrong");

  // Long back-up keeps the core stopped and the accumulator untouched
  // Counter stands in for a long repetition
  backup_long_a: assert property (@(posedge CLK) disable iff (!NRST)
    backup_cyc_r != CYC_ZERO |-> BACKUP && !PC_INC && !ACC_WE)
    else $error("back-up residency broken");

  // Main scenarios; the bench reaches all but arm_pdown_c
  arm_pdown_c: cover property (@(posedge CLK) disable iff (!NRST)
    run && INSTR == ARM_OPCODE ##1 run && INSTR == pdx_pkg::OP_PDOWN);
  stray_pdown_c: cover property (@(posedge CLK) disable iff (!NRST)
    run && INSTR == pdx_pkg::OP_PDOWN && !armed_r);
  or_exec_c: cover property (@(posedge CLK) disable iff (!NRST) is_or);
  port1_write_c: cover property (@(posedge CLK) disable iff (!NRST)
    is_port1 ##1 is_port1);
  port2_write_c: cover property (@(posedge CLK) disable iff (!NRST)
    is_port2 ##1 is_port1);
endmodule : pdx_exec

// [tb/pdx_port_load.sv]
// Purpose: Load model on the two output ports
// Assumes: Loads only sink current and drive nothing back
// Notes: Keeps the pin levels visible for debug
`timescale 1ns/10ps
module pdx_port_load (
  input wire logic [3:0] PORT_ONE,
  input wire logic [1:0] PORT_TWO
);
  // Nothing fed back, so no core input depends on the load
  logic [5:0] pin_level;
  assign pin_level = {PORT_TWO, PORT_ONE};
endmodule : pdx_port_load

// [tb/pdx_bench.sv]
// Purpose: Random and corner checks of the instruction executor
// Assumes: Arming opcode is the design's default
// Notes: Arming kept out of the random mix so back-up comes late
`timescale 1ns/10ps
module port_or_powerdown_instr_exec_bench;
  logic CLK = 0, NRST = 0, INSTR_VALID = 0, CARRY_IN = 0, ACC_WE, CARRY_OUT, SKIP, PC_INC;
  logic BACKUP, bk = 0, arm = 0;
  logic [9:0] INSTR = 10'h000;
  logic [3:0] ACC = 4'h0, RAM_NIBBLE = 4'h0, ACC_NXT, PORT_ONE, e1 = 4'h0;
  logic [1:0] PORT_TWO, e2 = 2'h0;
  logic [9:0] ops [5] = '{pdx_pkg::OP_PORT1, pdx_pkg::OP_PORT2, pdx_pkg::OP_OR,
    pdx_pkg::OP_PDOWN, 10'h000};
  int miscompares = 0, n_compared = 0;
  pdx_exec i_dut (.CLK(CLK), .NRST(NRST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .ACC(ACC), .CARRY_IN(CARRY_IN), .RAM_NIBBLE(RAM_NIBBLE), .ACC_NXT(ACC_NXT),
    .ACC_WE(ACC_WE), .CARRY_OUT(CARRY_OUT), .SKIP(SKIP), .PC_INC(PC_INC),
    .PORT_ONE(PORT_ONE), .PORT_TWO(PORT_TWO), .BACKUP(BACKUP));
  pdx_port_load i_load (.PORT_ONE(PORT_ONE), .PORT_TWO(PORT_TWO));
  // Free-running core clock
  initial forever #4 CLK = ~CLK;
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  // Drive one cycle, check mid-cycle, then advance the model
  task automatic step(input logic v, input logic [9:0] op);
    @(posedge CLK);
    INSTR_VALID <= v;
    INSTR <= op;
    ACC <= 4'($urandom);
    RAM_NIBBLE <= 4'($urandom);
    CARRY_IN <= 1'($urandom);
    @(negedge CLK);
    chk(ACC_WE, v && !bk && op == pdx_pkg::OP_OR);
    chk(ACC_NXT, ACC | RAM_NIBBLE);
    chk(CARRY_OUT, CARRY_IN);
    chk(SKIP, 1'h0);
    chk(PC_INC, v && !bk);
    chk(PORT_ONE, e1);
    chk(PORT_TWO, e2);
    chk(BACKUP, bk);
    if (v && !bk) begin
      if (op == pdx_pkg::OP_PORT1) e1 = ACC;
      if (op == pdx_pkg::OP_PORT2) e2 = ACC[1:0];
      if (op == pdx_pkg::OP_PDOWN && arm) bk = 1;
      arm = (op == pdx_pkg::OP_ARM_DEF);
    end
  endtask : step
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Random mix, then broken and true power-down sequences
  initial begin
    void'($urandom(88528));
    repeat (20) @(posedge CLK);
    NRST <= 1;
    for (int i = 0; i < 400; i++) step(1'($urandom), ops[$urandom % 5]);
    step(1, pdx_pkg::OP_ARM_DEF);
    step(1, pdx_pkg::OP_OR);
    step(1, pdx_pkg::OP_PDOWN);
    step(1, pdx_pkg::OP_ARM_DEF);
    step(0, pdx_pkg::OP_PORT1);
    step(1, pdx_pkg::OP_PDOWN);
    step(1, pdx_pkg::OP_PORT1);
    step(1, pdx_pkg::OP_OR);
    conclude();
  end
endmodule : port_or_powerdown_instr_exec_bench
